// *** serial_config_loader.v ***
// Serial configuration intake: active fetch from flash, passive intake, flash bridge.
//
// Operation
// - In one-lane active mode one configuration bit is taken from the flash per serial clock cycle.
// - In four-lane active mode four configuration bits are taken in parallel per serial clock cycle.
// - In active mode the block itself makes the serial clock that times every flash transfer.
// - With compression on, the shorter stream is accepted and expanded to the full image.
// - While chip enable is held high the block keeps off all active serial lines.
// - While the reconfiguration request is low the block stays in its reset stage.
// - Loaded user logic may bridge boundary-scan commands and data through to the flash.
// - In active mode outputs launch on a serial clock fall and data are caught on the next fall.
// - The flash select output is driven low for the whole active access.
`timescale 1ns/100ps
`default_nettype none
`include "serial_config_loader_defines.vh"

module serial_config_loader #(
  parameter [31:0] IMAGE_BYTES = `SCL_IMAGE_BYTES,
  parameter [7:0]  DUMMY_CYCLES = `SCL_DUMMY_CYCLES
) (
  // Clock and reset.
  input  wire       mclk,
  input  wire       nrst,
  // Configuration pins from the board.
  input  wire       reconfig_request_low,
  input  wire       chip_enable_in_low,
  input  wire       active_serial_scheme,
  input  wire       quad_lane_select,
  input  wire       compress_enable,
  // Serial clock pin, two-way.
  input  wire       config_serial_clock_in,
  output reg        config_serial_clock_out,
  output reg        config_serial_clock_oe,
  // Flash select and command line.
  output reg        flash_select_out_low,
  output reg        flash_select_oe,
  output reg        flash_command_out,
  output reg        flash_command_oe,
  // Serial data lines; bit 0 is serial_data_line_zero, bit 1 serial_data_line_one.
  input  wire [3:0] serial_data_in,
  // Flash bridge from user logic and the boundary-scan side.
  input  wire       boundary_scan_flash_bridge,
  input  wire       bridge_clock_in,
  input  wire       bridge_select_low_in,
  input  wire       bridge_data_in,
  output reg        bridge_data_out,
  // Expanded configuration stream and status.
  output wire [7:0] config_byte,
  output wire       config_byte_valid,
  output reg        config_done
);

  // Serial clock half period in system clocks, at least one.
  localparam HALF_RAW = (`SCL_CONFIG_SERIAL_CLOCK_HALF_NS + `SCL_MCLK_PERIOD_NS - 1) / `SCL_MCLK_PERIOD_NS;
  localparam [3:0] HALF_CYCLES = (HALF_RAW < 1) ? 4'd1 : HALF_RAW[3:0];
  localparam [5:0] CMD_BITS = `SCL_CMD_BITS;

  // One-hot states.
  localparam [6:0] ST_RESET   = 7'h01;
  localparam [6:0] ST_HOLD    = 7'h02;
  localparam [6:0] ST_CMD     = 7'h04;
  localparam [6:0] ST_DUMMY   = 7'h08;
  localparam [6:0] ST_READ    = 7'h10;
  localparam [6:0] ST_PASSIVE = 7'h20;
  localparam [6:0] ST_DONE    = 7'h40;

  // Two-flop synchronisers for every pin from outside this clock's domain except boundary_scan_flash_bridge, which is used directly.
  reg [12:0] pin_meta;
  reg [12:0] pin_sync;
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      // Idle levels: request high, serial clock high, bridge select high, so no false edge follows reset.
      pin_meta <= 13'h0821;
      pin_sync <= 13'h0821;
    end else begin
      pin_meta <= {bridge_data_in, bridge_select_low_in, bridge_clock_in, serial_data_in,
                   config_serial_clock_in, compress_enable, quad_lane_select,
                   active_serial_scheme, chip_enable_in_low, reconfig_request_low};
      pin_sync <= pin_meta;
    end
  end

  wire       req_low   = ~pin_sync[0];
  wire       ce_high   = pin_sync[1];
  wire       strap_as  = pin_sync[2];
  wire       strap_x4  = pin_sync[3];
  wire       strap_cmp = pin_sync[4];
  wire       link_clk  = pin_sync[5];
  wire [3:0] lane      = pin_sync[9:6];
  wire       br_clk    = pin_sync[10];
  wire       br_sel    = pin_sync[11];
  wire       br_data   = pin_sync[12];

  reg [6:0]  state;
  reg [1:0]  settle;
  reg        quad;
  reg        compress;
  reg        done_seen;
  reg [3:0]  div_cnt;
  reg        config_serial_clock;
  reg [31:0] cmd_shift;
  reg [5:0]  bit_cnt;
  reg [7:0]  rx_shift;
  reg [2:0]  rx_cnt;
  reg        pend;
  reg [7:0]  pend_byte;
  reg        link_prev;
  reg [31:0] byte_cnt;
  wire       exp_ready;

  wire as_run   = (state == ST_CMD) || (state == ST_DUMMY) || (state == ST_READ);
  // The clock pauses while a byte waits, so a long zero run never loses flash data.
  wire tick     = as_run && !pend && (div_cnt == HALF_CYCLES - 4'd1);
  wire fall     = tick && config_serial_clock;
  wire link_up  = link_clk && !link_prev;
  wire rx_last  = quad ? (rx_cnt == 3'd1) : (rx_cnt == 3'd7);
  wire [7:0] rx_next = quad ? {lane, rx_shift[7:4]} : {lane[1], rx_shift[7:1]};
  wire last_out = config_byte_valid && (byte_cnt == IMAGE_BYTES - 32'd1);
  wire bridge_on = (state == ST_DONE) && boundary_scan_flash_bridge && !ce_high;

  // Serial clock divider; the block is the clock's only source in active mode.
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      div_cnt <= 4'd0;
      config_serial_clock    <= 1'b1;
    end else if (!as_run) begin
      div_cnt <= 4'd0;
      config_serial_clock    <= 1'b1;
    end else if (!pend) begin
      if (tick) begin
        div_cnt <= 4'd0;
        config_serial_clock    <= ~config_serial_clock;
      end else begin
        div_cnt <= div_cnt + 4'd1;
      end
    end
  end

  // Sequencer: reset stage, hold-off, command, dummy, read, passive intake and done.
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state     <= ST_RESET;
      settle    <= 2'd0;
      quad      <= 1'b0;
      compress  <= 1'b0;
      done_seen <= 1'b0;
      cmd_shift <= 32'h0;
      bit_cnt   <= 6'd0;
      rx_shift  <= 8'h00;
      rx_cnt    <= 3'd0;
      pend      <= 1'b0;
      pend_byte <= 8'h00;
      link_prev <= 1'b1;
      byte_cnt  <= 32'h0;
      flash_command_out    <= 1'b1;
      flash_select_out_low <= 1'b1;
    end else begin
      link_prev <= link_clk;
      if (pend && exp_ready) begin
        pend <= 1'b0;
      end
      if (config_byte_valid) begin
        byte_cnt <= byte_cnt + 32'd1;
      end
      if (req_low) begin
        state                <= ST_RESET;
        settle               <= 2'd0;
        done_seen            <= 1'b0;
        pend                 <= 1'b0;
        flash_select_out_low <= 1'b1;
      end else if (last_out) begin
        state                <= ST_DONE;
        done_seen            <= 1'b1;
        flash_select_out_low <= 1'b1;
      end else begin
        case (state)
          ST_RESET: begin
            // Straps are caught here; the wait lets the synchronisers fill with real pin levels first.
            quad      <= strap_x4;
            compress  <= strap_cmp;
            byte_cnt  <= 32'h0;
            bit_cnt   <= 6'd0;
            rx_cnt    <= 3'd0;
            cmd_shift <= {(strap_x4 ? `SCL_CMD_READ_X4 : `SCL_CMD_READ_X1), `SCL_START_ADDR};
            if (settle != 2'd3) begin
              settle <= settle + 2'd1;
            end else if (done_seen) begin
              state <= ST_DONE;
            end else if (ce_high) begin
              state <= ST_HOLD;
            end else if (strap_as) begin
              state <= ST_CMD;
            end else begin
              state <= ST_PASSIVE;
            end
          end
          ST_HOLD: begin
            if (!ce_high) begin
              state <= ST_RESET;
            end
          end
          ST_CMD: begin
            if (ce_high) begin
              state                <= ST_HOLD;
              flash_select_out_low <= 1'b1;
            end else if (fall) begin
              flash_select_out_low <= 1'b0;
              if (bit_cnt != CMD_BITS) begin
                flash_command_out <= cmd_shift[31];
                cmd_shift         <= {cmd_shift[30:0], 1'b0};
                bit_cnt           <= bit_cnt + 6'd1;
              end else begin
                bit_cnt <= 6'd0;
                state   <= quad ? ST_DUMMY : ST_READ;
              end
            end
          end
          ST_DUMMY: begin
            if (ce_high) begin
              state                <= ST_HOLD;
              flash_select_out_low <= 1'b1;
            end else if (fall) begin
              if (bit_cnt == DUMMY_CYCLES[5:0] - 6'd1) begin
                state <= ST_READ;
              end
              bit_cnt <= bit_cnt + 6'd1;
            end
          end
          ST_READ: begin
            if (ce_high) begin
              state                <= ST_HOLD;
              flash_select_out_low <= 1'b1;
            end else if (fall) begin
              // One lane gives one bit per fall, four lanes give a nibble.
              rx_shift <= rx_next;
              rx_cnt   <= rx_last ? 3'd0 : rx_cnt + 3'd1;
              if (rx_last) begin
                pend      <= 1'b1;
                pend_byte <= rx_next;
              end
            end
          end
          ST_PASSIVE: begin
            // The host cannot be stalled; it must pace bytes behind zero runs.
            if (link_up) begin
              rx_shift <= {lane[0], rx_shift[7:1]};
              rx_cnt   <= rx_cnt + 3'd1;
              if (rx_cnt == 3'd7) begin
                pend      <= 1'b1;
                pend_byte <= {lane[0], rx_shift[7:1]};
              end
            end
          end
          ST_DONE: begin
            // Once done, the bridge steers select and command from its synced pins.
            if (bridge_on) begin
              flash_select_out_low <= br_sel;
              flash_command_out    <= br_data;
            end else begin
              flash_select_out_low <= 1'b1;
            end
          end
          default: begin
            state <= ST_RESET;
          end
        endcase
      end
    end
  end

  // Pin drivers: active fetch owns the flash lines, the bridge owns them once done.
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      config_serial_clock_out <= 1'b1;
      config_serial_clock_oe  <= 1'b0;
      flash_select_oe         <= 1'b0;
      flash_command_oe        <= 1'b0;
      bridge_data_out         <= 1'b0;
      config_done             <= 1'b0;
    end else begin
      config_done <= (state == ST_DONE) && !req_low;
      if (as_run && !ce_high && !req_low) begin
        config_serial_clock_out <= config_serial_clock;
        config_serial_clock_oe  <= 1'b1;
        flash_select_oe         <= 1'b1;
        flash_command_oe        <= 1'b1;
      end else if (state == ST_DONE && boundary_scan_flash_bridge && !ce_high) begin
        config_serial_clock_out <= br_clk;
        config_serial_clock_oe  <= 1'b1;
        flash_select_oe         <= 1'b1;
        flash_command_oe        <= 1'b1;
      end else begin
        config_serial_clock_out <= 1'b1;
        config_serial_clock_oe  <= 1'b0;
        flash_select_oe         <= 1'b0;
        flash_command_oe        <= 1'b0;
      end
      bridge_data_out <= lane[1];
    end
  end

  config_expander u_expander (
    .mclk            (mclk),
    .nrst            (nrst),
    .compress_enable (compress),
    .in_data         (pend_byte),
    .in_valid        (pend),
    .in_ready        (exp_ready),
    .out_data        (config_byte),
    .out_valid       (config_byte_valid)
  );

endmodule // serial_config_loader
`default_nettype wire

// *** serial_config_loader_defines.vh ***
// Constants shared by the serial configuration loader and its expander.
`ifndef SERIAL_CONFIG_LOADER_DEFINES_VH
`define SERIAL_CONFIG_LOADER_DEFINES_VH

// System clock period and serial clock half period, in nanoseconds.
`define SCL_MCLK_PERIOD_NS 20
`define SCL_CONFIG_SERIAL_CLOCK_HALF_NS   40

// Flash read commands for one-lane and four-lane fetch.
`define SCL_CMD_READ_X1    8'h03
`define SCL_CMD_READ_X4    8'h6b
`define SCL_CMD_BITS       32
`define SCL_START_ADDR     24'h000000
`define SCL_DUMMY_CYCLES   8

// Bytes of expanded image that complete a configuration.
`define SCL_IMAGE_BYTES    32'd4096

// Expander escape byte: followed by a count n, it stands for n+1 zero bytes.
`define SCL_ZERO_ESCAPE    8'h00

`endif

// *** config_expander.v ***
// Byte expander that turns a compressed configuration stream into the full image.
`timescale 1ns/100ps
`default_nettype none
`include "serial_config_loader_defines.vh"

module config_expander (
  // Clock and reset.
  input  wire       mclk,
  input  wire       nrst,
  // Mode.
  input  wire       compress_enable,
  // Compressed byte in.
  input  wire [7:0] in_data,
  input  wire       in_valid,
  output wire       in_ready,
  // Expanded byte out.
  output reg  [7:0] out_data,
  output reg        out_valid
);

  reg [7:0] run_left;
  reg       want_count;

  // A zero run in progress blocks intake; the loader stalls its clock on this.
  assign in_ready = (run_left == 8'h00);

  // Literal bytes pass; an escape and its count unfold into a run of zeros.
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      run_left   <= 8'h00;
      want_count <= 1'b0;
      out_data   <= 8'h00;
      out_valid  <= 1'b0;
    end else begin
      out_valid <= 1'b0;
      if (run_left != 8'h00) begin
        out_data  <= 8'h00;
        out_valid <= 1'b1;
        run_left  <= run_left - 8'h01;
      end else if (in_valid) begin
        if (want_count) begin
          want_count <= 1'b0;
          out_data   <= 8'h00;
          out_valid  <= 1'b1;
          run_left   <= in_data;
        end else if (compress_enable && in_data == `SCL_ZERO_ESCAPE) begin
          want_count <= 1'b1;
        end else begin
          out_data  <= in_data;
          out_valid <= 1'b1;
        end
      end
    end
  end

endmodule // config_expander
`default_nettype wire

// *** scl_checker.sv ***
// Concurrent checks on the serial configuration loader pins.
`timescale 1ns/100ps
`default_nettype none
module scl_checker (
  // Clock and reset.
  input wire logic       mclk,
  input wire logic       nrst,
  // Board pins in.
  input wire logic       reconfig_request_low,
  input wire logic       chip_enable_in_low,
  input wire logic       boundary_scan_flash_bridge,
  input wire logic [3:0] serial_data_in,
  // Pins and status out.
  input wire logic       config_serial_clock_out,
  input wire logic       config_serial_clock_oe,
  input wire logic       flash_select_out_low,
  input wire logic       flash_select_oe,
  input wire logic       flash_command_out,
  input wire logic       flash_command_oe,
  input wire logic       bridge_data_out,
  input wire logic       config_byte_valid,
  input wire logic       config_done
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  // Pin levels pass two sync flops, so each relation allows for that delay.
  hold_lines_off_a: assert property (chip_enable_in_low [*4]
    |-> !config_serial_clock_oe && !flash_select_oe && !flash_command_oe) else $error("Lines driven in hold.");
  reset_stage_a: assert property (!reconfig_request_low [*4]
    |-> !config_done && !config_byte_valid && (flash_select_out_low || !flash_select_oe)) else $error("Left reset stage.");
  select_whole_a: assert property (flash_select_oe && $past(flash_select_oe) && $rose(flash_select_out_low)
    |-> ##[0:4] config_done) else $error("Select rose mid access.");
  clock_high_a: assert property ($fell(config_serial_clock_out) && config_serial_clock_oe
    && $past(config_serial_clock_oe, 2) |-> $past(config_serial_clock_out, 2)) else $error("Short clock high phase.");
  command_fall_a: assert property ($changed(flash_command_out) && flash_command_oe
    && $past(flash_command_oe) && !config_done
    |-> ##1 $fell(config_serial_clock_out)) else $error("Command moved off a fall.");
  select_fall_a: assert property ($fell(flash_select_out_low) && flash_select_oe && !config_done
    |-> ##1 $fell(config_serial_clock_out)) else $error("Select fell off a fall.");
  done_sticky_a: assert property ($fell(config_done) |-> !$past(reconfig_request_low, 2)
    || !$past(reconfig_request_low, 3) || !$past(reconfig_request_low, 4)) else $error("Done dropped.");
  bridge_copy_a: assert property (boundary_scan_flash_bridge && $past(boundary_scan_flash_bridge, 3) && config_done
    |-> bridge_data_out == $past(serial_data_in[1], 3)) else $error("Bridge data not passed.");
  // Main scenarios seen at least once.
  cover property ($fell(flash_select_out_low));
  cover property (config_byte_valid ##1 config_byte_valid);
  cover property (boundary_scan_flash_bridge && config_done);
endmodule // scl_checker
bind serial_config_loader scl_checker i_chk (.mclk, .nrst, .reconfig_request_low, .chip_enable_in_low,
  .boundary_scan_flash_bridge, .serial_data_in, .config_serial_clock_out, .config_serial_clock_oe,
  .flash_select_out_low, .flash_select_oe, .flash_command_out, .flash_command_oe, .bridge_data_out,
  .config_byte_valid, .config_done);
`default_nettype wire

// *** flash_partner.sv ***
// Behavioural serial flash answering the loader's read command.
`timescale 1ns/100ps
`default_nettype none
module flash_partner (
  // Clock and pins.
  input  wire logic        mclk,
  input  wire logic        clk_pin,
  input  wire logic        sel_pin,
  input  wire logic        cmd_pin,
  input  wire logic        quad,
  // Data back and command seen.
  output var  logic [3:0]  dq,
  output var  logic [31:0] cmd_seen
);
  int   falls = 0;
  logic prev  = 1'b1;
  // Unit k of the image: a bit on line one, or a nibble low half first.
  function automatic logic [3:0] unit(input int k);
    logic [7:0] b;
    b = 8'h5a ^ 8'((quad ? k >> 1 : k >> 3) * 19);
    if (quad) return k[0] ? b[7:4] : b[3:0];
    return {~b[k & 7], ~b[k & 7], b[k & 7], ~b[k & 7]};
  endfunction
  // Start from a known level so the wandering lines never settle to unknown.
  initial dq = 4'h0;
  // A deselected flash lets its lines wander every cycle so stale data cannot pass for good data.
  // Acting on the falling system edge keeps the answer as prompt as a real flash after a clock fall.
  always @(negedge mclk) begin
    prev <= clk_pin;
    if (sel_pin) begin
      falls <= 0;
      dq    <= ~dq;
    end else if (prev && !clk_pin) begin
      falls <= falls + 1;
      dq    <= (falls >= (quad ? 40 : 32)) ? unit(falls - (quad ? 40 : 32)) : ~dq;
    end
    if (!prev && clk_pin && !sel_pin && falls >= 1 && falls <= 32) cmd_seen <= {cmd_seen[30:0], cmd_pin};
  end
endmodule // flash_partner
`default_nettype wire

// *** test_serial_config_loader.sv ***
// Self-checking bench for the serial configuration loader with a flash partner.
`timescale 1ns/100ps
`default_nettype none
module test_serial_config_loader;
  logic             mclk, nrst, reconfig_request_low, chip_enable_in_low, active_serial_scheme;
  logic             quad_lane_select, compress_enable, boundary_scan_flash_bridge, bridge_clock_in;
  logic             bridge_select_low_in, bridge_data_in, ps_clk, ps_bit;
  wire logic        config_serial_clock_in, config_serial_clock_out, config_serial_clock_oe, flash_select_out_low;
  wire logic        flash_select_oe, flash_command_out, flash_command_oe, bridge_data_out, config_byte_valid;
  wire logic        config_done;
  wire logic [3:0]  serial_data_in, flash_dq;
  wire logic [7:0]  config_byte;
  wire logic [31:0] cmd_seen;
  logic [7:0]       got[$];
  logic [2:0]       d1_hist;
  int               n_errors = 0, total_checks = 0, cycles = 0;
  // Passive rows: byte sent by the host beside the byte expected out.
  logic [15:0] rows [8] = '{16'h0202, 16'h1b1b, 16'heeee, 16'h0101, 16'hfafa, 16'h3c3c, 16'ha5a5, 16'h7e7e};
  // The clock pin follows the loader while it drives, else the host, which rests high.
  assign config_serial_clock_in = config_serial_clock_oe ? config_serial_clock_out : ps_clk;
  // While chip enable is high the cable owns the lines: it sends on line zero and reads back on line one.
  assign serial_data_in = (active_serial_scheme && !chip_enable_in_low) ? flash_dq : {~ps_bit, ps_clk, ~ps_bit, ps_bit};
  serial_config_loader #(.IMAGE_BYTES(32'd8)) i_dut (.mclk, .nrst, .reconfig_request_low, .chip_enable_in_low,
    .active_serial_scheme, .quad_lane_select, .compress_enable, .config_serial_clock_in, .config_serial_clock_out,
    .config_serial_clock_oe, .flash_select_out_low, .flash_select_oe, .flash_command_out, .flash_command_oe,
    .serial_data_in, .boundary_scan_flash_bridge, .bridge_clock_in, .bridge_select_low_in, .bridge_data_in,
    .bridge_data_out, .config_byte, .config_byte_valid, .config_done);
  flash_partner i_flash (.mclk, .clk_pin(config_serial_clock_in), .sel_pin(flash_select_out_low | ~flash_select_oe),
    .cmd_pin(flash_command_out), .quad(quad_lane_select), .dq(flash_dq), .cmd_seen);
  // System clock at 50 MHz.
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // Expanded bytes are kept in order; the cycle ceiling cuts a hang short.
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    d1_hist <= {d1_hist[1:0], serial_data_in[1]};
    if (config_byte_valid === 1'b1) got.push_back(config_byte);
    if (cycles == 30000) begin
      $display("ERROR %0t: cycle limit reached", $time);
      n_errors++;
      tally_and_finish();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d, errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Reset with new straps; all pin drives must be off while reset holds.
  task automatic restart(input logic act, input logic quad, input logic comp);
    @(posedge mclk);
    nrst                 <= 1'b0;
    active_serial_scheme <= act;
    quad_lane_select     <= quad;
    compress_enable      <= comp;
    repeat (2) @(posedge mclk);
    check({config_serial_clock_oe, flash_select_oe, flash_command_oe, config_done}, 0);
    nrst <= 1'b1;
    got.delete();
    repeat (8) @(posedge mclk);
  endtask
  // Host side: LSB first, one bit per 160 ns clock, data set while the clock is low.
  task automatic send_byte(input logic [7:0] b);
    for (int k = 0; k < 8; k++) begin
      ps_clk <= 1'b0;
      ps_bit <= b[k];
      repeat (4) @(posedge mclk);
      ps_clk <= 1'b1;
      repeat (4) @(posedge mclk);
    end
  endtask
  task automatic wait_done();
    for (int n = 0; n < 4000 && config_done !== 1'b1; n++) @(negedge mclk);
    check(config_done, 1);
  endtask
  function automatic logic [7:0] pat(input int i);
    return 8'h5a ^ 8'(i * 19);
  endfunction
  // Main sequence: passive rows, compressed stream, both fetch widths, bridge, reset stage, hold.
  initial begin
    {nrst, reconfig_request_low, chip_enable_in_low, active_serial_scheme} = 4'h4;
    {quad_lane_select, compress_enable, boundary_scan_flash_bridge, bridge_clock_in} = 4'h1;
    {bridge_select_low_in, bridge_data_in, ps_clk, ps_bit} = 4'ha;
    restart(1'b0, 1'b0, 1'b0);
    foreach (rows[i]) send_byte(rows[i][15:8]);
    wait_done();
    check(got.size(), 8);
    foreach (rows[i]) check(got[i], rows[i][7:0]);
    // A zero escape with count two stands for three zero bytes, so seven bytes fill the image.
    restart(1'b0, 1'b0, 1'b1);
    send_byte(8'h00);
    send_byte(8'h02);
    for (int i = 0; i < 5; i++) send_byte(rows[i][15:8]);
    wait_done();
    for (int i = 0; i < 8; i++) check(got[i], i < 3 ? 8'h00 : rows[i - 3][7:0]);
    for (int q = 0; q < 2; q++) begin
      restart(1'b1, q[0], 1'b0);
      wait_done();
      check(cmd_seen, q ? 32'h6b000000 : 32'h03000000);
      for (int i = 0; i < 8; i++) check(got[i], pat(i));
    end
    @(posedge mclk);
    boundary_scan_flash_bridge <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      repeat (4) @(posedge mclk);
      check(config_serial_clock_out, bridge_clock_in);
      check(flash_select_out_low, bridge_select_low_in);
      check(flash_command_out, bridge_data_in);
      check(bridge_data_out, d1_hist[2]);
      bridge_clock_in      <= ~bridge_clock_in;
      bridge_select_low_in <= i[3];
      bridge_data_in       <= i[1];
    end
    boundary_scan_flash_bridge <= 1'b0;
    reconfig_request_low       <= 1'b0;
    repeat (20) @(negedge mclk);
    check(config_done, 0);
    @(posedge mclk);
    reconfig_request_low <= 1'b1;
    restart(1'b1, 1'b0, 1'b0);
    repeat (40) @(posedge mclk);
    chip_enable_in_low <= 1'b1;
    repeat (8) @(negedge mclk);
    check({config_serial_clock_oe, flash_select_oe, flash_command_oe}, 0);
    @(posedge mclk);
    send_byte(8'h03);
    check(bridge_data_out, !ps_bit);
    check({config_serial_clock_oe, flash_select_oe, flash_command_oe}, 0);
    chip_enable_in_low <= 1'b0;
    repeat (20) @(posedge mclk);
    tally_and_finish();
  end
endmodule // test_serial_config_loader
`default_nettype wire
